// ===== hw/dus_pkg.sv
package dus_pkg;
  localparam int          DATA_W      = 8;
  localparam int          PORT_W      = 6;
  localparam int          NUM_CH      = 4;
  localparam int          ADDR_W      = 16;
  localparam int          FIFO_DEPTH  = 8;
  localparam int          CNT_W       = 3;
  localparam logic [7:0]  SEL_INIT    = 8'hfe;
  localparam logic [7:0]  SEL_ALL_HI  = 8'hff;
  localparam logic [2:0]  LOOP_INIT   = 3'h4;
  localparam logic [2:0]  CNT_ZERO    = 3'h0;
  localparam logic [15:0] ADDR_STEP   = 16'h0001;
  localparam logic [1:0]  LOOP_BITS   = 2'h0;
  localparam logic [5:0]  EN_IDLE     = 6'h3f;
  localparam logic [7:0]  BUS_RESET   = 8'h00;
  localparam logic [15:0] ADDR_RESET  = 16'h0000;
  localparam logic [1:0]  SETUP_CYC   = 2'h1;
  localparam logic [1:0]  PULSE_CYC   = 2'h1;
  localparam logic [1:0]  HOLD_CYC    = 2'h1;

  typedef enum logic [2:0] {
    DUS_IDLE, DUS_FETCH, DUS_WAIT, DUS_SETUP, DUS_PULSE, DUS_HOLD
  } dus_state_t;
endpackage : dus_pkg

// ===== hw/dus_stream_if.sv
`timescale 1ns/10ps
// byte stream between fetch side and fifo, fifo and output side
interface dus_stream_if;
  logic [7:0] data;
  logic       valid;
  logic       ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : dus_stream_if

// ===== hw/dus_fifo.sv
`timescale 1ns/10ps
// small synchronous fifo, registered pointers, honest full/empty
module dus_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic  clk,
  input  wire logic  sys_rst,
  // streams
  dus_stream_if.snk  wr,
  dus_stream_if.src  rd
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0]      wr_ptr;
  logic [PW:0]      rd_ptr;
  logic             full;
  logic             empty;
  logic             do_wr;
  logic             do_rd;

  // full when pointers differ only in wrap bit
  assign empty    = (wr_ptr == rd_ptr);
  assign full     = (wr_ptr[PW] != rd_ptr[PW]) && (wr_ptr[PW-1:0] == rd_ptr[PW-1:0]);
  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data  = mem[rd_ptr[PW-1:0]];
  assign do_wr    = wr.valid && !full;
  assign do_rd    = rd.ready && !empty;

  // storage has no reset, only pointers need one
  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wr_ptr[PW-1:0]] <= wr.data;
    end
  end

  // pointer updates
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

  fifo_no_overflow_a: assert property (@(posedge clk) disable iff (sys_rst)
    full |=> !(wr_ptr != $past(wr_ptr) && $past(full)))
    else $error("fifo wrote while full");
endmodule : dus_fifo

// ===== hw/dus_seq.sv
`timescale 1ns/10ps
module dus_seq (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // control
  input  wire logic        start,
  input  wire logic [15:0] base_addr,
  output logic             busy,
  output logic             done,
  // memory read port, one cycle latency
  output logic             mem_rd,
  output logic [15:0]      mem_addr,
  input  wire logic [7:0]  mem_data,
  // converter pins
  output logic [7:0]       dac_bus,
  output logic [5:0]       dac_en_n
);
  dus_pkg::dus_state_t state;
  logic [7:0]  sel;
  logic [2:0]  loop_cnt;
  logic [2:0]  fetch_cnt;
  logic        rd_pend;
  logic [1:0]  dwell;

  dus_stream_if fill ();
  dus_stream_if drain ();

  // fetched bytes are queued so memory latency stalls the pins only before the first byte
  dus_fifo #(.WIDTH(dus_pkg::DATA_W), .DEPTH(dus_pkg::FIFO_DEPTH)) u_fifo (
    .clk     (clk),
    .sys_rst (sys_rst),
    .wr      (fill.snk),
    .rd      (drain.src)
  );

  assign fill.data   = mem_data;
  assign fill.valid  = rd_pend;
  assign drain.ready = (state == dus_pkg::DUS_WAIT);

  // fetch side: issue one read per channel while fifo has room
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_rd    <= 1'b0;
      mem_addr  <= dus_pkg::ADDR_RESET;
      rd_pend   <= 1'b0;
      fetch_cnt <= dus_pkg::CNT_ZERO;
    end else begin
      rd_pend <= mem_rd;
      if (start && state == dus_pkg::DUS_IDLE) begin
        mem_addr  <= base_addr;
        fetch_cnt <= dus_pkg::LOOP_INIT;
        mem_rd    <= 1'b0;
      end else if (!mem_rd && !rd_pend && fetch_cnt != dus_pkg::CNT_ZERO
                   && fill.ready) begin
        mem_rd <= 1'b1;
      end else if (mem_rd) begin
        // one read at a time keeps back-pressure exact
        mem_rd    <= 1'b0;
        mem_addr  <= mem_addr + dus_pkg::ADDR_STEP;
        fetch_cnt <= fetch_cnt - 3'h1;
      end
    end
  end

  // output side sequencer
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state    <= dus_pkg::DUS_IDLE;
      sel      <= dus_pkg::SEL_ALL_HI;
      loop_cnt <= dus_pkg::CNT_ZERO;
      dwell    <= 2'h0;
      dac_bus  <= dus_pkg::BUS_RESET;
      dac_en_n <= dus_pkg::EN_IDLE;
      busy     <= 1'b0;
      done     <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state)
        dus_pkg::DUS_IDLE: begin
          dac_en_n <= dus_pkg::EN_IDLE;
          if (start) begin
            sel      <= dus_pkg::SEL_INIT;
            loop_cnt <= dus_pkg::LOOP_INIT;
            busy     <= 1'b1;
            state    <= dus_pkg::DUS_WAIT;
          end
        end
        dus_pkg::DUS_WAIT: begin
          // bus only changes here, with every enable high
          if (drain.valid) begin
            dac_bus <= drain.data;
            dwell   <= dus_pkg::SETUP_CYC;
            state   <= dus_pkg::DUS_SETUP;
          end
        end
        dus_pkg::DUS_SETUP: begin
          if (dwell == dus_pkg::SETUP_CYC) begin
            // only the selected line goes low, others stay high
            dac_en_n <= sel[dus_pkg::PORT_W-1:0];
            dwell    <= dus_pkg::PULSE_CYC;
            state    <= dus_pkg::DUS_PULSE;
          end
        end
        dus_pkg::DUS_PULSE: begin
          dac_en_n <= dus_pkg::EN_IDLE;
          // rotate now so the next channel is ready before the bus changes
          sel      <= {sel[6:0], sel[7]};
          loop_cnt <= loop_cnt - 3'h1;
          state    <= dus_pkg::DUS_HOLD;
        end
        dus_pkg::DUS_HOLD: begin
          // bus held one cycle after rise so latch sees stable data
          if (loop_cnt == dus_pkg::CNT_ZERO) begin
            busy  <= 1'b0;
            done  <= 1'b1;
            state <= dus_pkg::DUS_IDLE;
          end else begin
            state <= dus_pkg::DUS_WAIT;
          end
        end
        default: begin
          state <= dus_pkg::DUS_IDLE;
        end
      endcase
    end
  end

  // assertions
  one_low_en_a: assert property (@(posedge clk) disable iff (sys_rst)
    $countones(~dac_en_n) <= 1)
    else $error("more than one enable low");
  spare_lines_hi_a: assert property (@(posedge clk) disable iff (sys_rst)
    dac_en_n[5:4] == 2'h3)
    else $error("unused enable line driven low");
  pulse_one_cycle_a: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(&dac_en_n) |=> &dac_en_n)
    else $error("enable pulse not one cycle");
  bus_setup_a: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(&dac_en_n) |-> $stable(dac_bus))
    else $error("bus changed as enable fell");
  bus_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(&dac_en_n) |=> $stable(dac_bus))
    else $error("bus changed right after enable rose");
  bus_quiet_a: assert property (@(posedge clk) disable iff (sys_rst)
    !$stable(dac_bus) |-> &dac_en_n)
    else $error("bus changed while a latch was open");
  first_chan_a: assert property (@(posedge clk) disable iff (sys_rst)
    (state == dus_pkg::DUS_IDLE && start) |=> sel == dus_pkg::SEL_INIT)
    else $error("select pattern not initialised");
  rotate_sel_a: assert property (@(posedge clk) disable iff (sys_rst)
    state == dus_pkg::DUS_PULSE |=> sel == {$past(sel[6:0]), $past(sel[7])})
    else $error("select not rotated");
  four_updates_a: assert property (@(posedge clk) disable iff (sys_rst)
    done |-> $past(loop_cnt) == dus_pkg::CNT_ZERO && $past(sel) == 8'hef)
    else $error("run ended after wrong count");
  addr_step_a: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(mem_rd) |-> mem_addr == $past(mem_addr) + dus_pkg::ADDR_STEP)
    else $error("address not stepped by one");

  // enable port and shared bus ownership
  pulse_ends_high_a: assert property (@(posedge clk) disable iff (sys_rst)
    state == dus_pkg::DUS_PULSE |=> dac_en_n == dus_pkg::EN_IDLE)
    else $error("enables not all high after pulse");
  idle_all_high_a: assert property (@(posedge clk) disable iff (sys_rst)
    state == dus_pkg::DUS_IDLE |-> dac_en_n == dus_pkg::EN_IDLE)
    else $error("enable low while idle");
  setup_before_low_a: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(&dac_en_n) |-> $past(state) == dus_pkg::DUS_SETUP)
    else $error("enable fell without bus setup");
  bus_only_in_wait_a: assert property (@(posedge clk) disable iff (sys_rst)
    !$stable(dac_bus) |-> $past(state) == dus_pkg::DUS_WAIT)
    else $error("bus changed outside wait");
  bus_from_fifo_a: assert property (@(posedge clk) disable iff (sys_rst)
    (state == dus_pkg::DUS_WAIT && drain.valid) |=> dac_bus == $past(drain.data))
    else $error("bus not loaded from queued byte");
  sel_one_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
    state != dus_pkg::DUS_IDLE |-> $countones(~sel) == 1)
    else $error("select pattern lost its single zero");

  // loop count and start handling; a start while busy must leave the run alone
  loop_loaded_a: assert property (@(posedge clk) disable iff (sys_rst)
    (state == dus_pkg::DUS_IDLE && start) |=> loop_cnt == dus_pkg::LOOP_INIT)
    else $error("loop counter not loaded");
  busy_ignores_start_a: assert property (@(posedge clk) disable iff (sys_rst)
    (state == dus_pkg::DUS_WAIT && start) |=> loop_cnt == $past(loop_cnt) && sel == $past(sel))
    else $error("start while busy disturbed the run");
  done_ends_busy_a: assert property (@(posedge clk) disable iff (sys_rst)
    done |-> !busy)
    else $error("busy still high at done");

  // fetch side: one read strobe at a time, never more than four per run
  base_loaded_a: assert property (@(posedge clk) disable iff (sys_rst)
    (state == dus_pkg::DUS_IDLE && start) |=> mem_addr == $past(base_addr))
    else $error("base address not taken with start");
  read_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
    mem_rd |=> !mem_rd)
    else $error("read strobe longer than one cycle");
  fetch_limit_a: assert property (@(posedge clk) disable iff (sys_rst)
    fetch_cnt <= dus_pkg::LOOP_INIT)
    else $error("fetch count above four");

  // main scenarios: a full run, the last channel, a stall, a restart, a stray start
  run_done_c: cover property (@(posedge clk) disable iff (sys_rst) done);
  back_to_back_c: cover property (@(posedge clk) disable iff (sys_rst)
    done ##1 (start && state == dus_pkg::DUS_IDLE));
  start_busy_c: cover property (@(posedge clk) disable iff (sys_rst) busy && start);
  chan4_c: cover property (@(posedge clk) disable iff (sys_rst) dac_en_n == 6'h37);
  wait_stall_c: cover property (@(posedge clk) disable iff (sys_rst)
    state == dus_pkg::DUS_WAIT && !drain.valid);
endmodule : dus_seq

// ===== sim/dus_dac_model.sv
`timescale 1ns/10ps
// four converter input latches sharing one data bus
module dus_dac_model (
  // shared bus and enables
  input  wire logic [7:0] dac_bus,
  input  wire logic [5:0] dac_en_n,
  // latched converter codes
  output logic      [7:0] dac_out [4]
);
  // transparent while enable is low, holds once it returns high
  always @* begin
    for (int i = 0; i < 4; i++) begin
      if (dac_en_n[i] == 1'b0) dac_out[i] = dac_bus;
    end
  end
endmodule : dus_dac_model

// ===== sim/tb_four_channel_dac_update_sequencer.sv
`timescale 1ns/10ps
module tb_four_channel_dac_update_sequencer;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        start = 1'b0;
  logic [15:0] base_addr = 16'h0000;
  logic        busy, done, mem_rd;
  logic [15:0] mem_addr;
  logic [7:0]  mem_data = 8'h00;
  logic [7:0]  dac_bus;
  logic [5:0]  dac_en_n;
  logic [7:0]  dac_out [4];
  logic [7:0]  mem [65536];
  logic        rd_q = 1'b0;
  logic [15:0] addr_q = 16'h0000;
  int          n_errors = 0;
  int          cmp_count = 0;
  int          cyc = 0;

  dus_seq u_dut (.clk(clk), .sys_rst(sys_rst), .start(start), .base_addr(base_addr),
    .busy(busy), .done(done), .mem_rd(mem_rd), .mem_addr(mem_addr),
    .mem_data(mem_data), .dac_bus(dac_bus), .dac_en_n(dac_en_n));
  dus_dac_model u_dac (.dac_bus(dac_bus), .dac_en_n(dac_en_n), .dac_out(dac_out));

  always #50 clk = ~clk;
  // one-cycle memory; data scrambles once its cycle is over
  always @(posedge clk) begin
    rd_q <= mem_rd;
    addr_q <= mem_addr;
  end
  always @(negedge clk) mem_data <= rd_q ? mem[addr_q] : ~mem_data;
  // hang guard, runs are about twenty cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      results();
    end
  end

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // one run of four updates, watching the pins every cycle
  task automatic run(input logic [15:0] base, input bit poke);
    int          n;
    int          k;
    logic [7:0]  pb;
    logic [5:0]  pe;
    logic [5:0]  e;
    k = 0;
    pb = dac_bus;
    pe = dac_en_n;
    start = 1'b1;
    base_addr = base;
    for (n = 0; n < 80 && done !== 1'b1; n++) begin
      @(negedge clk);
      start = (poke && n == 5); // a start mid-run must be ignored
      base_addr = base + 16'h0010;
      e = ~(6'h01 << k);
      if (dac_en_n !== 6'h3f) begin
        chk("enable", {10'h000, dac_en_n}, {10'h000, e});
        chk("bus", {8'h00, dac_bus}, {8'h00, mem[base + 16'(k)]});
        chk("setup", {8'h00, pb}, {8'h00, dac_bus});
        chk("busy_run", {15'h0000, busy}, 16'h0001);
        k++;
      end else if (pe !== 6'h3f) begin
        chk("hold", {8'h00, dac_bus}, {8'h00, pb});
      end
      pb = dac_bus;
      pe = dac_en_n;
    end
    start = 1'b0;
    chk("done", {15'h0000, done}, 16'h0001);
    chk("count", 16'(k), 16'h0004);
    @(negedge clk);
    chk("busy", {15'h0000, busy}, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      chk("latch", {8'h00, dac_out[i]}, {8'h00, mem[base + 16'(i)]});
    end
    $display("test run %h done", base);
  endtask : run

  // reset in mid-run, then a clean run must follow
  task automatic mid_reset();
    start = 1'b1;
    base_addr = 16'h0200;
    repeat (10) @(negedge clk);
    start = 1'b0;
    sys_rst = 1'b1;
    @(negedge clk);
    chk("rst_en", {10'h000, dac_en_n}, 16'h003f);
    chk("rst_busy", {14'h0000, busy, mem_rd}, 16'h0000);
    sys_rst = 1'b0;
    run(16'h0100, 1'b0);
    $display("test mid_reset done");
  endtask : mid_reset

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results

  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = 8'(i * 37 + 11);
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    run(16'h0040, 1'b0);
    run(16'hfffe, 1'b1); // pointer wraps, stray start mid-run
    mid_reset();
    results();
  end
endmodule : tb_four_channel_dac_update_sequencer
